// *** hwte_defs.svh ***
`ifndef HWTE_DEFS_SVH
`define HWTE_DEFS_SVH

// clock and time units
`define HWTE_CLK_PERIOD_NS 10
`define HWTE_US_IN_NS 1000

// register map, byte addresses on the plain register port
`define HWTE_ADDR_W 8
`define HWTE_DATA_W 32
`define HWTE_OFS_CTRL 8'h00
`define HWTE_OFS_EXP_RAW 8'h04
`define HWTE_OFS_EXP_BASE 8'h08
`define HWTE_OFS_DELAY 8'h0C
`define HWTE_OFS_EXP_EFF 8'h10
`define HWTE_OFS_STATUS 8'h14
`define HWTE_OFS_EVT_STATUS 8'h18
`define HWTE_OFS_EVT_CLEAR 8'h1C
`define HWTE_OFS_EVT_ENABLE 8'h20

// control register fields
`define HWTE_CTRL_W 5
`define HWTE_CTRL_GATE 0
`define HWTE_CTRL_ORIGIN_SW 1
`define HWTE_CTRL_EDGE_FALL 2
`define HWTE_CTRL_PULSE_MODE 3
`define HWTE_CTRL_AUTO_EN 4
`define HWTE_CTRL_SW_TRIG 5
`define HWTE_RST_CTRL 5'h00

// exposure values, all in microseconds or raw counts
`define HWTE_EXP_W 24
`define HWTE_RST_EXP_RAW 24'h000096
`define HWTE_RST_EXP_BASE 24'h000014
`define HWTE_RST_DELAY 24'h000000
`define HWTE_MIN_RAW 24'h000001
`define HWTE_MIN_BASE 24'h000001
`define HWTE_MAX_RAW 24'h989680
`define HWTE_MAX_EXPOSURE_US 24'h989680
`define HWTE_MIN_EXPOSURE_US 24

// event bits
`define HWTE_EVT_W 3
`define HWTE_EVT_START 0
`define HWTE_EVT_END 1
`define HWTE_EVT_OVER 2
`define HWTE_RST_EVT 3'h0

`endif

// *** hwte_exposure_ctrl.sv ***
// Chosen here: the address-and-strobe port and the register offsets.
`include "hwte_defs.svh"

module hwte_exposure_ctrl #(
   parameter int CYC_PER_US = `HWTE_US_IN_NS / `HWTE_CLK_PERIOD_NS,
   parameter int MIN_EXPOSURE_US = `HWTE_MIN_EXPOSURE_US
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [`HWTE_ADDR_W-1:0] reg_addr,
   input wire logic [`HWTE_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [`HWTE_DATA_W-1:0] reg_rdata,
   input wire logic ext_acq_start_trigger_in,
   input wire logic readout_busy,
   input wire logic [`HWTE_EXP_W-1:0] auto_exposure_us,
   output logic exposure_active,
   output logic trigger_ready,
   output logic irq
);

   localparam int EW = `HWTE_EXP_W;
   localparam logic [EW-1:0] MIN_US = EW'(MIN_EXPOSURE_US);

   // configuration
   logic [`HWTE_CTRL_W-1:0] ctrl;
   logic [`HWTE_CTRL_W-1:0] next_ctrl;
   logic [EW-1:0] exp_raw;
   logic [EW-1:0] next_exp_raw;
   logic [EW-1:0] exp_base;
   logic [EW-1:0] next_exp_base;
   logic [EW-1:0] start_trigger_delay_us;
   logic [EW-1:0] next_start_trigger_delay_us;
   logic sw_trig_cmd;

   // exposure value chain
   logic [2*EW-1:0] manual_product;
   logic [EW-1:0] manual_us;
   logic [EW-1:0] auto_us;
   logic [EW-1:0] chosen_us;
   logic [EW-1:0] exposure_time_us_setting;
   logic auto_active;

   // trigger conditioning
   logic trig_prev;
   logic next_trig_prev;
   logic trigger_gate_enable;
   logic trigger_origin_select;
   logic trigger_edge_select;
   logic pulse_width_exposure_mode;
   logic pulse_ctl;
   logic level_active;
   logic prev_level_active;
   logic start_edge;
   logic hw_start;
   logic sw_start;
   logic free_start;
   logic ready_now;

   // sequencing
   hwte_pkg::hwte_state_t state;
   hwte_pkg::hwte_state_t next_state;
   logic next_exposure_active;
   logic next_trigger_ready;
   logic delay_load;
   logic exp_load;
   logic delay_busy;
   logic delay_done;
   logic exp_busy;
   logic exp_done;
   logic ev_start;
   logic ev_end;
   logic ev_over;

   // events and read path
   logic [`HWTE_EVT_W-1:0] evt_status;
   logic [`HWTE_EVT_W-1:0] next_evt_status;
   logic [`HWTE_EVT_W-1:0] evt_enable;
   logic [`HWTE_EVT_W-1:0] next_evt_enable;
   logic [`HWTE_EVT_W-1:0] evt_set;
   logic [`HWTE_EVT_W-1:0] evt_clr;
   logic next_irq;
   logic [`HWTE_DATA_W-1:0] next_reg_rdata;

   assign trigger_gate_enable = ctrl[`HWTE_CTRL_GATE];
   assign trigger_origin_select = ctrl[`HWTE_CTRL_ORIGIN_SW];
   assign trigger_edge_select = ctrl[`HWTE_CTRL_EDGE_FALL];
   assign pulse_width_exposure_mode = ctrl[`HWTE_CTRL_PULSE_MODE];

   // ---------------- configuration registers ----------------
   always_comb begin
      next_ctrl = ctrl;
      next_exp_raw = exp_raw;
      next_exp_base = exp_base;
      next_start_trigger_delay_us = start_trigger_delay_us;
      next_evt_enable = evt_enable;
      sw_trig_cmd = 1'b0;
      if (reg_wr) begin
         case (reg_addr)
            `HWTE_OFS_CTRL: begin
               next_ctrl = reg_wdata[`HWTE_CTRL_W-1:0];
               sw_trig_cmd = reg_wdata[`HWTE_CTRL_SW_TRIG];
            end
            `HWTE_OFS_EXP_RAW: begin
               // raw count held inside 1..10000000
               if (reg_wdata[EW-1:0] < `HWTE_MIN_RAW) begin
                  next_exp_raw = `HWTE_MIN_RAW;
               end else if (reg_wdata[EW-1:0] > `HWTE_MAX_RAW) begin
                  next_exp_raw = `HWTE_MAX_RAW;
               end else begin
                  next_exp_raw = reg_wdata[EW-1:0];
               end
            end
            `HWTE_OFS_EXP_BASE: begin
               if (reg_wdata[EW-1:0] < `HWTE_MIN_BASE) begin
                  next_exp_base = `HWTE_MIN_BASE;
               end else begin
                  next_exp_base = reg_wdata[EW-1:0];
               end
            end
            `HWTE_OFS_DELAY: begin
               next_start_trigger_delay_us = reg_wdata[EW-1:0];
            end
            `HWTE_OFS_EVT_ENABLE: begin
               next_evt_enable = reg_wdata[`HWTE_EVT_W-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= `HWTE_RST_CTRL;
         exp_raw <= `HWTE_RST_EXP_RAW;
         exp_base <= `HWTE_RST_EXP_BASE;
         start_trigger_delay_us <= `HWTE_RST_DELAY;
         evt_enable <= `HWTE_RST_EVT;
      end else begin
         ctrl <= next_ctrl;
         exp_raw <= next_exp_raw;
         exp_base <= next_exp_base;
         start_trigger_delay_us <= next_start_trigger_delay_us;
         evt_enable <= next_evt_enable;
      end
   end

   // ---------------- exposure value ----------------
   // the product saturates at the top of the range so a large base with a
   // large raw count cannot wrap into a short exposure
   assign manual_product = exp_raw * exp_base;
   assign manual_us = (manual_product > (2*EW)'(`HWTE_MAX_EXPOSURE_US)) ?
                      `HWTE_MAX_EXPOSURE_US : manual_product[EW-1:0];
   assign auto_us = (auto_exposure_us > `HWTE_MAX_EXPOSURE_US) ?
                    `HWTE_MAX_EXPOSURE_US : auto_exposure_us;
   // auto value taken directly, no multiple-of-base step
   assign auto_active = ctrl[`HWTE_CTRL_AUTO_EN] &
                        ~pulse_width_exposure_mode;
   assign chosen_us = auto_active ? auto_us : manual_us;
   assign exposure_time_us_setting = (chosen_us < MIN_US) ?
                                     MIN_US : chosen_us;

   // ---------------- trigger conditioning ----------------
   // active level of the pulse: high for rising, low for falling activation
   assign level_active = trigger_edge_select ?
                         ~ext_acq_start_trigger_in :
                         ext_acq_start_trigger_in;
   assign prev_level_active = trigger_edge_select ? ~trig_prev : trig_prev;
   assign start_edge = level_active & ~prev_level_active;
   assign next_trig_prev = ext_acq_start_trigger_in;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         trig_prev <= 1'b0;
      end else begin
         trig_prev <= next_trig_prev;
      end
   end

   assign hw_start = trigger_gate_enable & ~trigger_origin_select & start_edge;
   assign sw_start = trigger_gate_enable & trigger_origin_select & sw_trig_cmd;
   // with gating off the block starts itself whenever it is able to
   assign free_start = ~trigger_gate_enable;
   // pulse width needs a line; with the software origin exposure is timed
   assign pulse_ctl = pulse_width_exposure_mode & trigger_gate_enable &
                      ~trigger_origin_select;
   // ready also waits for the programmed time, even in pulse-width mode
   assign ready_now = (state == hwte_pkg::hwte_st_idle) & ~exp_busy;

   // ---------------- sequencer ----------------
   always_comb begin
      next_state = state;
      delay_load = 1'b0;
      exp_load = 1'b0;
      ev_start = 1'b0;
      ev_end = 1'b0;
      ev_over = 1'b0;
      case (state)
         hwte_pkg::hwte_st_idle: begin
            if (ready_now && hw_start &&
                start_trigger_delay_us != '0) begin
               delay_load = 1'b1;
               next_state = hwte_pkg::hwte_st_delay;
            end else if (ready_now && (hw_start || sw_start || free_start)) begin
               // software and free-run starts never see the delay
               exp_load = 1'b1;
               ev_start = 1'b1;
               next_state = hwte_pkg::hwte_st_expose;
            end else if (hw_start || sw_start) begin
               ev_over = 1'b1;
            end
         end
         hwte_pkg::hwte_st_delay: begin
            if (hw_start || sw_start) begin
               ev_over = 1'b1;
            end
            if (!trigger_gate_enable || trigger_origin_select) begin
               // delay dropped when its trigger path is switched away
               next_state = hwte_pkg::hwte_st_idle;
            end else if (delay_done) begin
               exp_load = 1'b1;
               ev_start = 1'b1;
               next_state = hwte_pkg::hwte_st_expose;
            end
         end
         hwte_pkg::hwte_st_expose: begin
            if (hw_start || sw_start) begin
               ev_over = 1'b1;
            end
            if (pulse_ctl) begin
               if (!level_active && readout_busy) begin
                  next_state = hwte_pkg::hwte_st_extend;
               end else if (!level_active) begin
                  ev_end = 1'b1;
                  next_state = hwte_pkg::hwte_st_idle;
               end
            end else if (exp_done) begin
               ev_end = 1'b1;
               next_state = hwte_pkg::hwte_st_idle;
            end
         end
         hwte_pkg::hwte_st_extend: begin
            if (hw_start || sw_start) begin
               ev_over = 1'b1;
            end
            if (!readout_busy) begin
               ev_end = 1'b1;
               next_state = hwte_pkg::hwte_st_idle;
            end
         end
         default: begin
            next_state = hwte_pkg::hwte_st_idle;
         end
      endcase
      next_exposure_active = (next_state == hwte_pkg::hwte_st_expose) ||
                             (next_state == hwte_pkg::hwte_st_extend);
      next_trigger_ready = ready_now;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= hwte_pkg::hwte_st_idle;
         exposure_active <= 1'b0;
         trigger_ready <= 1'b0;
      end else begin
         state <= next_state;
         exposure_active <= next_exposure_active;
         trigger_ready <= next_trigger_ready;
      end
   end

   hwte_us_timer #(
      .CYC_PER_US(CYC_PER_US),
      .CNT_W(EW)
   ) u_delay_tmr (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .load(delay_load),
      .load_us(start_trigger_delay_us),
      .busy(delay_busy),
      .done(delay_done)
   );

   hwte_us_timer #(
      .CYC_PER_US(CYC_PER_US),
      .CNT_W(EW)
   ) u_exp_tmr (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .load(exp_load),
      .load_us(exposure_time_us_setting),
      .busy(exp_busy),
      .done(exp_done)
   );

   // ---------------- events, interrupt, read path ----------------
   always_comb begin
      evt_set = '0;
      evt_set[`HWTE_EVT_START] = ev_start;
      evt_set[`HWTE_EVT_END] = ev_end;
      evt_set[`HWTE_EVT_OVER] = ev_over;
      evt_clr = '0;
      if (reg_wr && reg_addr == `HWTE_OFS_EVT_CLEAR) begin
         evt_clr = reg_wdata[`HWTE_EVT_W-1:0];
      end
      // a new event in the clearing cycle survives the clear
      next_evt_status = (evt_status & ~evt_clr) | evt_set;
      next_irq = |(next_evt_status & next_evt_enable);
      next_reg_rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            `HWTE_OFS_CTRL: begin
               next_reg_rdata[`HWTE_CTRL_W-1:0] = ctrl;
            end
            `HWTE_OFS_EXP_RAW: begin
               next_reg_rdata[EW-1:0] = exp_raw;
            end
            `HWTE_OFS_EXP_BASE: begin
               next_reg_rdata[EW-1:0] = exp_base;
            end
            `HWTE_OFS_DELAY: begin
               next_reg_rdata[EW-1:0] = start_trigger_delay_us;
            end
            `HWTE_OFS_EXP_EFF: begin
               next_reg_rdata[EW-1:0] = exposure_time_us_setting;
            end
            `HWTE_OFS_STATUS: begin
               next_reg_rdata[7:0] = {auto_active, delay_busy, exp_busy,
                                      readout_busy, trigger_ready,
                                      exposure_active, state};
            end
            `HWTE_OFS_EVT_STATUS: begin
               next_reg_rdata[`HWTE_EVT_W-1:0] = evt_status;
            end
            `HWTE_OFS_EVT_ENABLE: begin
               next_reg_rdata[`HWTE_EVT_W-1:0] = evt_enable;
            end
            default: begin
               next_reg_rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         evt_status <= `HWTE_RST_EVT;
         irq <= 1'b0;
         reg_rdata <= '0;
      end else begin
         evt_status <= next_evt_status;
         irq <= next_irq;
         reg_rdata <= next_reg_rdata;
      end
   end

endmodule

// *** hwte_exposure_ctrl_sva.sv ***
`include "hwte_defs.svh"

module hwte_exposure_ctrl_sva (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [`HWTE_ADDR_W-1:0] reg_addr,
   input wire logic [`HWTE_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [`HWTE_DATA_W-1:0] reg_rdata,
   input wire logic ext_acq_start_trigger_in,
   input wire logic readout_busy,
   input wire logic [`HWTE_EXP_W-1:0] auto_exposure_us,
   input wire logic exposure_active,
   input wire logic trigger_ready,
   input wire logic irq
);
   logic [4:0] ctrl;
   logic [4:0] next_ctrl;
   logic dly_zero;
   logic next_dly_zero;
   logic lvl;
   logic hw;
   logic pw;

   // shadow of the mode bits, tracked from bus writes only
   always_comb begin
      next_ctrl = ctrl;
      next_dly_zero = dly_zero;
      if (reg_wr && reg_addr == `HWTE_OFS_CTRL) begin
         next_ctrl = reg_wdata[4:0];
      end
      if (reg_wr && reg_addr == `HWTE_OFS_DELAY) begin
         next_dly_zero = (reg_wdata[23:0] == 24'h000000);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= 5'h00;
         dly_zero <= 1'b1;
      end else begin
         ctrl <= next_ctrl;
         dly_zero <= next_dly_zero;
      end
   end

   assign lvl = ctrl[`HWTE_CTRL_EDGE_FALL] ? !ext_acq_start_trigger_in
                                            : ext_acq_start_trigger_in;
   assign hw = ctrl[`HWTE_CTRL_GATE] && !ctrl[`HWTE_CTRL_ORIGIN_SW];
   assign pw = hw && ctrl[`HWTE_CTRL_PULSE_MODE];

   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   a_rise_pulse_end: assert property (
      pw && !ctrl[2] && exposure_active && $fell(lvl) && !readout_busy
      |=> !exposure_active) else $error("rising pulse exposure kept on");
   a_fall_pulse_end: assert property (
      pw && ctrl[2] && exposure_active && $fell(lvl) && !readout_busy
      |=> !exposure_active) else $error("falling pulse exposure kept on");
   a_pulse_hold: assert property (
      pw && exposure_active && lvl |=> exposure_active)
      else $error("exposure ended while pulse active");
   a_readout_extend: assert property (
      pw && exposure_active && readout_busy |=> exposure_active)
      else $error("exposure ended during readout");
   a_busy_not_ready: assert property (
      exposure_active && $past(exposure_active) |-> !trigger_ready)
      else $error("ready shown during exposure");
   a_start_prompt: assert property (
      hw && dly_zero && trigger_ready && !exposure_active && $stable(ctrl)
      && $rose(lvl) |=> exposure_active)
      else $error("hardware start not taken");
   a_delay_holds: assert property (
      hw && !dly_zero && trigger_ready && $stable(ctrl) && $rose(lvl)
      |=> !exposure_active [*2]) else $error("delay not applied");
   a_sw_start: assert property (
      reg_wr && reg_addr == `HWTE_OFS_CTRL && reg_wdata[5] && reg_wdata[0]
      && reg_wdata[1] && ctrl[0] && ctrl[1] && trigger_ready
      |-> ##[1:3] exposure_active) else $error("software start delayed");
endmodule

bind hwte_exposure_ctrl hwte_exposure_ctrl_sva i_hwte_exposure_ctrl_sva (
   .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .ext_acq_start_trigger_in(ext_acq_start_trigger_in),
   .readout_busy(readout_busy), .auto_exposure_us(auto_exposure_us),
   .exposure_active(exposure_active), .trigger_ready(trigger_ready),
   .irq(irq));

// *** hwte_pkg.sv ***
package hwte_pkg;

   typedef enum logic [1:0] {
      hwte_st_idle = 2'b00,
      hwte_st_delay = 2'b01,
      hwte_st_expose = 2'b10,
      hwte_st_extend = 2'b11
   } hwte_state_t;

endpackage

// *** hwte_trig_src.sv ***
module hwte_trig_src (
   input wire logic ref_clk,
   output logic trig,
   output logic readout_busy
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      trig = 1'b0;
      readout_busy = 1'b0;
   end

   // line active for exactly width cycles, moved just after a clock edge
   task automatic pulse(input logic idle, input int width);
      trig <= !idle;
      repeat (width) @(posedge ref_clk);
      trig <= idle;
   endtask

   task automatic park(input logic idle);
      trig <= idle;
      @(posedge ref_clk);
   endtask

   // readout of the previous frame, begun at the same edge as a pulse
   task automatic busy(input int width);
      readout_busy <= 1'b1;
      repeat (width) @(posedge ref_clk);
      readout_busy <= 1'b0;
   endtask
endmodule

// *** hwte_us_timer.sv ***
`include "hwte_defs.svh"

// microsecond down-counter: load starts it, done pulses once at expiry
module hwte_us_timer #(
   parameter int CYC_PER_US = `HWTE_US_IN_NS / `HWTE_CLK_PERIOD_NS,
   parameter int CNT_W = `HWTE_EXP_W
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [CNT_W-1:0] load_us,
   output logic busy,
   output logic done
);

   localparam int PRE_W = $clog2(CYC_PER_US + 1);

   logic [PRE_W-1:0] pre;
   logic [PRE_W-1:0] next_pre;
   logic [CNT_W-1:0] remain;
   logic [CNT_W-1:0] next_remain;
   logic next_busy;
   logic next_done;
   logic tick;

   assign tick = (pre == PRE_W'(CYC_PER_US - 1));

   always_comb begin
      next_pre = pre;
      next_remain = remain;
      next_busy = busy;
      next_done = 1'b0;
      if (load) begin
         // a reload while running restarts from zero
         next_pre = '0;
         next_remain = load_us;
         next_busy = (load_us != '0);
         next_done = (load_us == '0);
      end else if (busy) begin
         if (tick) begin
            next_pre = '0;
            next_remain = remain - CNT_W'(1);
            if (remain == CNT_W'(1)) begin
               next_busy = 1'b0;
               next_done = 1'b1;
            end
         end else begin
            next_pre = pre + PRE_W'(1);
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pre <= '0;
         remain <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         pre <= next_pre;
         remain <= next_remain;
         busy <= next_busy;
         done <= next_done;
      end
   end

endmodule

// *** test_hw_trigger_exposure_timing.sv ***
`include "hwte_defs.svh"

module test_hw_trigger_exposure_timing;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk;
   logic rst_n;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic trig;
   logic readout_busy;
   logic [23:0] auto_exposure_us;
   logic exposure_active;
   logic trigger_ready;
   logic irq;
   int fail_count;
   int compares;
   int lat;
   int len;
   logic [31:0] d;

   hwte_exposure_ctrl #(.CYC_PER_US(2))
      i_hwte_exposure_ctrl (.ref_clk(ref_clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ext_acq_start_trigger_in(trig), .readout_busy(readout_busy),
      .auto_exposure_us(auto_exposure_us),
      .exposure_active(exposure_active), .trigger_ready(trigger_ready),
      .irq(irq));
   hwte_trig_src i_hwte_trig_src (.ref_clk(ref_clk), .trig(trig),
      .readout_busy(readout_busy));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic print_verdict();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // strobe dropped then one idle edge, so no strobe is set twice at once
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a,
                         input logic [31:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge ref_clk);
      if (what != "") check(what, d, exp);
   endtask

   task automatic wait_ready();
      int n;
      n = 0;
      // bound covers the free-run exposure begun at reset release
      while (trigger_ready !== 1'b1 && n < 8000) begin
         @(posedge ref_clk);
         #1 n++;
      end
      if (n >= 8000) begin
         fail_count++;
         print_verdict();
      end
      @(posedge ref_clk);
   endtask

   // cycles to exposure start, then cycles of exposure
   task automatic expo(output int l, output int w);
      l = 0;
      w = 0;
      while (exposure_active !== 1'b1 && l < 3000) begin
         @(posedge ref_clk);
         #1 l++;
      end
      while (exposure_active === 1'b1 && w < 30000) begin
         @(posedge ref_clk);
         #1 w++;
      end
      if (l >= 3000 || w >= 30000) begin
         fail_count++;
         print_verdict();
      end
   endtask

   initial begin
      rst_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h00000000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      auto_exposure_us = 24'h000025;
      fail_count = 0;
      compares = 0;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      // gate on with software origin stops the free run and keeps line quiet
      wr(`HWTE_OFS_CTRL, 32'h00000003);
      rd_chk("raw_rst", `HWTE_OFS_EXP_RAW, 32'h00000096);
      rd_chk("base_rst", `HWTE_OFS_EXP_BASE, 32'h00000014);
      rd_chk("eff_rst", `HWTE_OFS_EXP_EFF, 32'h00000BB8);
      rd_chk("evt_en_rst", `HWTE_OFS_EVT_ENABLE, 32'h00000000);
      rd_chk("unmapped", 8'h40, 32'h00000000);
      wr(`HWTE_OFS_EXP_RAW, 32'h00000000);
      rd_chk("raw_zero", `HWTE_OFS_EXP_RAW, 32'h00000001);
      wr(`HWTE_OFS_EXP_BASE, 32'h00000001);
      rd_chk("eff_min", `HWTE_OFS_EXP_EFF, 32'h00000018);
      wr(`HWTE_OFS_EXP_RAW, 32'h00FFFFFF);
      rd_chk("raw_max", `HWTE_OFS_EXP_RAW, 32'h00989680);
      rd_chk("eff_max", `HWTE_OFS_EXP_EFF, 32'h00989680);
      wr(`HWTE_OFS_EXP_RAW, 32'h00000001);
      wr(`HWTE_OFS_EXP_BASE, 32'h00989680);
      rd_chk("eff_base_max", `HWTE_OFS_EXP_EFF, 32'h00989680);
      // exposure set to the 24 us minimum, 48 cycles; the 10, 20 and 30 cycle
      // pulses below undercut it on purpose
      wr(`HWTE_OFS_EXP_BASE, 32'h00000018);
      $display("test registers done");
      wr(`HWTE_OFS_EVT_ENABLE, 32'h00000007);
      wait_ready();
      wr(`HWTE_OFS_CTRL, 32'h00000001);
      fork
         begin
            i_hwte_trig_src.pulse(1'b0, 5);
            repeat (10) @(posedge ref_clk);
            i_hwte_trig_src.pulse(1'b0, 5);
         end
         expo(lat, len);
      join
      check("timed_lat", lat, 1);
      check("timed_len", len, 49);
      rd_chk("evt_all", `HWTE_OFS_EVT_STATUS, 32'h00000007);
      check("irq_set", irq, 1'b1);
      wr(`HWTE_OFS_EVT_CLEAR, 32'h00000007);
      rd_chk("evt_clr", `HWTE_OFS_EVT_STATUS, 32'h00000000);
      check("irq_clr", irq, 1'b0);
      $display("test timed done");
      wait_ready();
      wr(`HWTE_OFS_CTRL, 32'h00000009);
      fork
         i_hwte_trig_src.pulse(1'b0, 60);
         i_hwte_trig_src.busy(30);
         expo(lat, len);
      join
      check("pulse_len", len, 60);
      wait_ready();
      fork
         i_hwte_trig_src.pulse(1'b0, 20);
         i_hwte_trig_src.busy(40);
         expo(lat, len);
      join
      check("extend_len", len, 40);
      wait_ready();
      fork
         i_hwte_trig_src.pulse(1'b0, 10);
         expo(lat, len);
      join
      check("short_len", len, 10);
      check("ready_held", trigger_ready, 1'b0);
      $display("test rising pulse done");
      wait_ready();
      wr(`HWTE_OFS_CTRL, 32'h0000000B);
      i_hwte_trig_src.park(1'b1);
      wr(`HWTE_OFS_CTRL, 32'h0000000D);
      fork
         i_hwte_trig_src.pulse(1'b1, 30);
         expo(lat, len);
      join
      check("fall_lat", lat, 1);
      check("fall_len", len, 30);
      wait_ready();
      wr(`HWTE_OFS_CTRL, 32'h00000003);
      i_hwte_trig_src.park(1'b0);
      $display("test falling pulse done");
      wr(`HWTE_OFS_DELAY, 32'h00000003);
      wr(`HWTE_OFS_CTRL, 32'h00000001);
      fork
         i_hwte_trig_src.pulse(1'b0, 5);
         expo(lat, len);
      join
      check("dly_lat", 32'(lat >= 8 && lat <= 10), 1);
      check("dly_len", len, 49);
      wait_ready();
      wr(`HWTE_OFS_DELAY, 32'h00000032);
      wr(`HWTE_OFS_CTRL, 32'h00000003);
      fork
         wr(`HWTE_OFS_CTRL, 32'h00000023);
         expo(lat, len);
      join
      check("sw_lat", 32'(lat <= 3), 1);
      check("sw_len", len, 49);
      $display("test delay done");
      wr(`HWTE_OFS_CTRL, 32'h00000013);
      rd_chk("eff_auto", `HWTE_OFS_EXP_EFF, 32'h00000025);
      auto_exposure_us <= 24'h000010;
      rd_chk("eff_auto_min", `HWTE_OFS_EXP_EFF, 32'h00000018);
      auto_exposure_us <= 24'h000025;
      rd_chk("", `HWTE_OFS_STATUS, 32'h00000000);
      check("auto_on", d[7], 1'b1);
      wr(`HWTE_OFS_CTRL, 32'h0000001B);
      rd_chk("eff_pw_auto", `HWTE_OFS_EXP_EFF, 32'h00000018);
      rd_chk("", `HWTE_OFS_STATUS, 32'h00000000);
      check("auto_off", d[7], 1'b0);
      $display("test auto done");
      print_verdict();
   end
endmodule
